/* File: rtl/uhie_enable_bank.sv */
// Enable bank: set-only and clear-only write ports on one enable word.
// Assumes one-cycle write strobes from the bus slave.
`timescale 1ns/1ps
module uhie_enable_bank (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write strobes and data
  input  wire logic        set_we,
  input  wire logic        clr_we,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // Enable state
  output      logic [31:0] enable_q
);

  typedef struct packed {
    logic [31:0] en;
  } uhie_bank_state_t;

  uhie_bank_state_t state_r;
  uhie_bank_state_t state_nxt;

  // Byte lanes expand to a bit mask
  function automatic logic [31:0] uhie_lane_mask(input logic [3:0] s);
    uhie_lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ==========================================================================
  // Set and clear; clear runs after set so a simultaneous pair leaves it off
  always_comb begin
    state_nxt = state_r;
    if (set_we) begin
      state_nxt.en = state_r.en | (wdata & uhie_lane_mask(wstrb)
                     & uhie_pkg::ENABLE_IMPL_MASK);
    end
    if (clr_we) begin
      state_nxt.en = state_nxt.en & ~(wdata & uhie_lane_mask(wstrb));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{en: uhie_pkg::ENABLE_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign enable_q = state_r.en;

endmodule

/* File: rtl/uhie_event_flags.sv */
// Event flag word: sticky bits set by controller events, cleared by writing one.
// Assumes event inputs are synchronous one-cycle or level pulses.
`timescale 1ns/1ps
module uhie_event_flags (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Events and software clear
  input  wire logic [31:0] events,
  input  wire logic        clr_we,
  input  wire logic [31:0] clr_mask,
  // Flag state
  output      logic [31:0] flags_q
);

  typedef struct packed {
    logic [31:0] flags;
  } uhie_flag_state_t;

  uhie_flag_state_t state_r;
  uhie_flag_state_t state_nxt;

  // ==========================================================================
  // Clear first, then set, so an event in the clearing cycle is kept
  always_comb begin
    state_nxt = state_r;
    if (clr_we) begin
      state_nxt.flags = state_r.flags & ~clr_mask;
    end
    state_nxt.flags = state_nxt.flags | (events & uhie_pkg::EVENT_IMPL_MASK);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '{flags: uhie_pkg::EVENT_RESET};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign flags_q = state_r.flags;

endmodule

/* File: rtl/uhie_pkg.sv */
// Package for the USB host interrupt enable block: register map, field layout, resets.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package uhie_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [15:0] EVENT_FLAGS_OFS  = 16'hD00C;
  localparam logic [15:0] ENABLE_SET_OFS   = 16'hD010;
  localparam logic [15:0] ENABLE_CLEAR_OFS = 16'hD014;
  localparam logic [15:0] IRQ_STATE_OFS    = 16'hD018;

  // ==========================================================================
  // Field positions
  localparam int MASTER_GATE_BIT  = 31;
  localparam int OWNERSHIP_BIT    = 30;
  localparam int ROOT_PORT_BIT    = 6;
  localparam int FRAME_WRAP_BIT   = 5;
  localparam int FATAL_ERROR_BIT  = 4;
  localparam int RESUME_BIT       = 3;
  localparam int FRAME_BEGIN_BIT  = 2;
  localparam int DONE_LIST_BIT    = 1;
  localparam int SCHED_OVERRUN_BIT = 0;

  // Implemented bits: 31, 30 and 6..0 for enables, 30 and 6..0 for events; bits 29..7 are reserved
  localparam logic [31:0] ENABLE_IMPL_MASK = 32'hC000007F;
  localparam logic [31:0] EVENT_IMPL_MASK  = 32'h4000007F;

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [31:0] ENABLE_RESET = 32'h00000000;
  localparam logic [31:0] EVENT_RESET  = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

/* File: rtl/uhie_top.sv */
// Interrupt enable logic of a USB host controller with an AXI4-Lite register slave.
// Assumes events are synchronous to clk; one clock, asynchronous active-low reset.
`timescale 1ns/1ps

// Function
// - Each enable bit other than bit 31 governs the event flag at the same bit position.
// - The interrupt is raised while any flag is set, its enable set, and the gate set.
// - Writing one to an enable bit sets it and writing zero leaves it alone.
// - Reading the enable register returns all enable bits with no side effect.
// - Bit 31 is the master gate, reset to zero, set by one, zero writes ignored.
// - Bit 30 enables the ownership-change interrupt and resets to zero.
// - Bit 6 enables the root-port change interrupt and resets to zero.
// - Bit 5 enables the frame-count wrap interrupt and resets to zero.
// - Bit 4 enables the fatal-error interrupt and resets to zero.
// - Bit 3 enables the resume-detected interrupt and resets to zero.
// - Bit 2 enables the frame-begin interrupt and resets to zero.
// - Bit 1 enables the done-list-written interrupt and resets to zero.
// - Bit 0 enables the scheduling-overrun interrupt and resets to zero.
// - Event flags are set by events only and cleared by software writing one.
// - Writing one to the clear register clears the matching enable bit.
module uhie_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  // AXI4-Lite write response
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  // AXI4-Lite read data
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Controller events, one bit per flag position
  input  wire logic [31:0] host_events,
  // Controller core view and interrupt
  output      logic        master_irq_gate,
  output      logic [31:0] irq_enable_reg,
  output      logic        irq_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic        aw_held;
    logic [15:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
  } uhie_top_state_t;

  uhie_top_state_t state_r;
  uhie_top_state_t state_nxt;

  logic [31:0] enable_q;
  logic [31:0] flags_q;
  logic        wr_fire;
  logic        set_we;
  logic        clr_we;
  logic        flag_clr_we;
  logic        irq_state_we;
  logic [31:0] wmask;
  logic        ar_fire;
  logic        pending;

  // Byte lanes expand to a bit mask
  function automatic logic [31:0] uhie_lane_mask(input logic [3:0] s);
    uhie_lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Word-aligned address match against a register offset
  function automatic logic uhie_hit(input logic [15:0] a, input logic [15:0] ofs);
    uhie_hit = (a[15:2] == ofs[15:2]);
  endfunction

  // ==========================================================================
  // Write decode: address and data may arrive in either order
  assign wr_fire      = state_r.aw_held && state_r.w_held && !state_r.bvalid;
  assign set_we       = wr_fire && uhie_hit(state_r.aw_addr, uhie_pkg::ENABLE_SET_OFS);
  assign clr_we       = wr_fire && uhie_hit(state_r.aw_addr, uhie_pkg::ENABLE_CLEAR_OFS);
  assign flag_clr_we  = wr_fire && uhie_hit(state_r.aw_addr, uhie_pkg::EVENT_FLAGS_OFS);
  assign irq_state_we = wr_fire && uhie_hit(state_r.aw_addr, uhie_pkg::IRQ_STATE_OFS);
  assign wmask        = state_r.w_data & uhie_lane_mask(state_r.w_strb);
  assign ar_fire      = s_axi_arvalid && s_axi_arready;

  // Handshake outputs come straight from the holding flags
  assign s_axi_awready = !state_r.aw_held;
  assign s_axi_wready  = !state_r.w_held;
  assign s_axi_arready = !state_r.rvalid;

  // ==========================================================================
  // Enable word with set and clear ports
  uhie_enable_bank u_enable (
    .clk      (clk),
    .rst_n    (rst_n),
    .set_we   (set_we),
    .clr_we   (clr_we),
    .wdata    (state_r.w_data),
    .wstrb    (state_r.w_strb),
    .enable_q (enable_q)
  );

  // Sticky event flags
  uhie_event_flags u_flags (
    .clk      (clk),
    .rst_n    (rst_n),
    .events   (host_events),
    .clr_we   (flag_clr_we),
    .clr_mask (wmask),
    .flags_q  (flags_q)
  );

  // ==========================================================================
  // Interrupt: bitwise pairing of flag and enable, then the master gate
  assign pending = |(flags_q & enable_q & uhie_pkg::EVENT_IMPL_MASK)
                   && enable_q[uhie_pkg::MASTER_GATE_BIT];

  // ==========================================================================
  // Bus channel and read mux logic
  always_comb begin
    state_nxt = state_r;
    // Capture address and data independently
    if (s_axi_awvalid && !state_r.aw_held) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.w_held) begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = s_axi_wdata;
      state_nxt.w_strb = s_axi_wstrb;
    end
    // Response once both halves are held; the irq state word is read-only
    if (wr_fire) begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held  = 1'b0;
      state_nxt.bvalid  = 1'b1;
      if (set_we || clr_we || flag_clr_we || irq_state_we) begin
        state_nxt.bresp = uhie_pkg::RESP_OKAY;
      end else begin
        state_nxt.bresp = uhie_pkg::RESP_SLVERR;
      end
    end else if (state_r.bvalid && s_axi_bready) begin
      state_nxt.bvalid = 1'b0;
    end
    // Reads have no side effect on any register
    if (ar_fire) begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rresp  = uhie_pkg::RESP_OKAY;
      if (uhie_hit(s_axi_araddr, uhie_pkg::ENABLE_SET_OFS) ||
          uhie_hit(s_axi_araddr, uhie_pkg::ENABLE_CLEAR_OFS)) begin
        state_nxt.rdata = enable_q & uhie_pkg::ENABLE_IMPL_MASK;
      end else if (uhie_hit(s_axi_araddr, uhie_pkg::EVENT_FLAGS_OFS)) begin
        state_nxt.rdata = flags_q;
      end else if (uhie_hit(s_axi_araddr, uhie_pkg::IRQ_STATE_OFS)) begin
        state_nxt.rdata = {31'h00000000, pending};
      end else begin
        state_nxt.rdata = 32'h00000000;
        state_nxt.rresp = uhie_pkg::RESP_SLVERR;
      end
    end else if (state_r.rvalid && s_axi_rready) begin
      state_nxt.rvalid = 1'b0;
    end
    // Registered interrupt level, one cycle behind the flags
    state_nxt.irq = pending;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_bvalid    = state_r.bvalid;
  assign s_axi_bresp     = state_r.bresp;
  assign s_axi_rvalid    = state_r.rvalid;
  assign s_axi_rdata     = state_r.rdata;
  assign s_axi_rresp     = state_r.rresp;
  assign irq_out         = state_r.irq;
  assign irq_enable_reg  = enable_q;
  assign master_irq_gate = enable_q[uhie_pkg::MASTER_GATE_BIT];

endmodule

/* File: verif/tb.sv */
// Self-checking bench for uhie_top: enable set and clear, flags and interrupt.
// Drives the AXI4-Lite slave and the event inputs directly.
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Signals
  localparam logic [15:0] A_FLG = uhie_pkg::EVENT_FLAGS_OFS;
  localparam logic [15:0] A_SET = uhie_pkg::ENABLE_SET_OFS;
  localparam logic [15:0] A_CLR = uhie_pkg::ENABLE_CLEAR_OFS;
  logic        clk = 1'h0, rst_n = 1'h0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, host_events = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        master_irq_gate, irq_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, irq_enable_reg, rd, ex;
  int          error_cnt = 0, total_checks = 0;
  int          bits [9] = '{0, 1, 2, 3, 4, 5, 6, 30, 31};

  uhie_top u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .host_events, .master_irq_gate, .irq_enable_reg, .irq_out);

  // 20 MHz clock
  initial forever #25 clk = ~clk;

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Ready is looked at on the falling edge, so the drop lands on the next rising edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic ta, tw, tk;
    int   n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tk = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tk) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) error_cnt++;
    if (n == 40) wrap_up();
  endtask

  task automatic rdr(input logic [15:0] a);
    logic ta, tk;
    int   n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      ta = s_axi_arvalid & s_axi_arready;
      tk = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tk) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) error_cnt++;
    if (n == 40) wrap_up();
  endtask

  // One-cycle event pulse; interrupt is due two edges later
  task automatic ev(input logic [31:0] m);
    @(posedge clk);
    host_events <= m;
    @(posedge clk);
    host_events <= 32'h0;
    @(posedge clk);
    @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_set;
    ex = 32'h0;
    rdr(A_SET);
    chk(rd, uhie_pkg::ENABLE_RESET);
    chk({30'h0, rs}, {30'h0, uhie_pkg::RESP_OKAY});
    foreach (bits[i]) begin
      wr(A_SET, 32'h1 << bits[i]);
      ex |= 32'h1 << bits[i];
      rdr(A_SET);
      chk(rd, ex);
    end
    wr(A_SET, 32'h0);
    chk({30'h0, rs}, {30'h0, uhie_pkg::RESP_OKAY});
    chk(irq_enable_reg, ex);
    wr(A_SET, 32'hFFFFFFFF);
    rdr(A_SET);
    chk(rd, uhie_pkg::ENABLE_IMPL_MASK);
  endtask

  // Partial clear, zero clear, then a reset in mid-run
  task automatic t_clr;
    wr(A_CLR, 32'h40000041);
    rdr(A_CLR);
    chk(rd, 32'h8000003E);
    wr(A_CLR, 32'h0);
    chk(irq_enable_reg, 32'h8000003E);
    chk({31'h0, master_irq_gate}, 32'h1);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    chk(irq_enable_reg, 32'h0);
  endtask

  // Each event bit alone: a foreign event must not interrupt, its own must
  task automatic t_irq;
    int o;
    for (int i = 0; i < 8; i++) begin
      o = bits[(i + 1) % 8];
      wr(A_SET, 32'h80000000 | (32'h1 << bits[i]));
      ev(32'h1 << o);
      chk({31'h0, irq_out}, 32'h0);
      ev(32'h1 << bits[i]);
      chk({31'h0, irq_out}, 32'h1);
      rdr(A_FLG);
      chk(rd, (32'h1 << o) | (32'h1 << bits[i]));
      wr(A_FLG, rd);
      @(negedge clk);
      chk({31'h0, irq_out}, 32'h0);
      wr(A_CLR, 32'hFFFFFFFF);
    end
  endtask

  // Gate opened after the flag, reserved event ignored, gate closed again
  task automatic t_gate;
    wr(A_SET, 32'h40000000);
    ev(32'h40000400);
    chk({31'h0, irq_out}, 32'h0);
    wr(A_SET, 32'h80000000);
    @(negedge clk);
    chk({31'h0, irq_out}, 32'h1);
    rdr(uhie_pkg::IRQ_STATE_OFS);
    chk(rd, 32'h1);
    rdr(A_FLG);
    chk(rd, 32'h40000000);
    wr(A_CLR, 32'h80000000);
    @(negedge clk);
    chk({31'h0, irq_out}, 32'h0);
    wr(16'hD020, 32'hFFFFFFFF);
    chk({30'h0, rs}, {30'h0, uhie_pkg::RESP_SLVERR});
    chk(irq_enable_reg, 32'h40000000);
    // Unmapped read answers an error with zero data
    rdr(16'hD020);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, uhie_pkg::RESP_SLVERR});
    // The pending word is read-only: a write is accepted and changes nothing
    wr(uhie_pkg::IRQ_STATE_OFS, 32'hFFFFFFFF);
    chk({30'h0, rs}, {30'h0, uhie_pkg::RESP_OKAY});
    chk(irq_enable_reg, 32'h40000000);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    t_set();
    t_clr();
    t_irq();
    t_gate();
    wrap_up();
  end
endmodule

/* File: verif/uhie_properties.sv */
// Checker for uhie_top: read handshake, enable word and interrupt timing.
// Bound to every uhie_top instance; sees only its ports.
`timescale 1ns/1ps
module uhie_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Read channel
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Write response
  input wire logic        s_axi_bvalid,
  // Events and interrupt side
  input wire logic [31:0] host_events,
  input wire logic        master_irq_gate,
  input wire logic [31:0] irq_enable_reg,
  input wire logic        irq_out
);
  // ==========================================================================
  // Properties, all in the one clock domain
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Event on an enabled bit while the gate is open
  sequence s_armed;
    ((host_events & irq_enable_reg & uhie_pkg::EVENT_IMPL_MASK) != 32'h0) && master_irq_gate;
  endsequence
  // Software left the enables alone for the flag edge
  sequence s_kept;
    $stable(irq_enable_reg);
  endsequence

  a_irq_follows: assert property (s_armed ##1 s_kept |=> irq_out)
    else $error("interrupt missing after enabled event");
  a_irq_cause: assert property (irq_out |-> $past(master_irq_gate) &&
    (($past(irq_enable_reg) & uhie_pkg::EVENT_IMPL_MASK) != 32'h0))
    else $error("interrupt without gate or enable");
  a_gate_bit: assert property (master_irq_gate == irq_enable_reg[31])
    else $error("gate output differs from bit 31");
  a_resv_zero: assert property (irq_enable_reg[29:7] == 23'h0)
    else $error("reserved enable bits set");
  a_en_by_write: assert property ((irq_enable_reg != $past(irq_enable_reg)) |->
    $rose(s_axi_bvalid)) else $error("enables moved without a write");
  a_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_cause: assert property ($rose(s_axi_rvalid) |->
    $past(s_axi_arvalid && s_axi_arready)) else $error("read data without request");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
endmodule

bind uhie_top uhie_properties u_props (.clk, .rst_n, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_bvalid, .host_events, .master_irq_gate, .irq_enable_reg, .irq_out);
